// ---- qbs_consts.svh ----
// Constants of the quad burst SRAM port
`ifndef QBS_CONSTS_SVH
`define QBS_CONSTS_SVH
`define QBS_LANE_W 9
`define QBS_BURST_LEN 3'h4
`define QBS_RD_LEAD 2'h2
`define QBS_BUF_DEPTH 2'h2
`define QBS_PHASE_K 1'b0
`endif

// ---- qbs_ctl_model.sv ----
// Behavioural memory controller on the far side of the quad burst SRAM port
module qbs_ctl_model (
  // Timing from the port
  input wire logic clk,
  input wire logic kRise,
  // Command and write data
  output logic readPortSelectN,
  output logic writePortSelectN,
  output logic [5:0] addr,
  output logic [17:0] wrData,
  output logic [1:0] byteLaneWriteSelectN,
  // Read stream
  output logic rdReady
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: both ports deselected, no lane selected
  initial begin
    readPortSelectN = 1'b1;
    writePortSelectN = 1'b1;
    addr = 6'h00;
    wrData = 18'h00000;
    byteLaneWriteSelectN = 2'h3;
    rdReady = 1'b1;
  end

  // One operation; returns on the last data beat, which is also the beat of the first
  // read word, so the caller can look at it in time
  task automatic burst(input logic rd, input logic wr, input logic [5:0] a, input logic hold,
                       input logic [17:0] d [4], input logic [1:0] l [4]);
    @(negedge clk);
    while (kRise !== 1'b1) @(negedge clk);
    readPortSelectN = ~rd;
    writePortSelectN = ~wr;
    addr = a;
    @(negedge clk);
    readPortSelectN = ~(rd & hold);
    writePortSelectN = ~(wr & hold);
    addr = a + 6'h08; // Hold repeats the request at the next K rise elsewhere
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      if (i == 1) begin
        readPortSelectN = 1'b1;
        writePortSelectN = 1'b1;
        addr = ~a;
      end
      wrData = d[i];
      byteLaneWriteSelectN = l[i];
    end
    // Released data must not look like the last word
    fork
      begin
        @(negedge clk);
        wrData = ~wrData;
        byteLaneWriteSelectN = 2'h3;
      end
    join_none
  endtask

  // Read, then both selects at the next K rise, where the write must win; it writes one word
  // above the read so that its beats meet the later read words in the array
  task automatic rdThenWr(input logic [5:0] a, input logic [17:0] d [4]);
    @(negedge clk);
    while (kRise !== 1'b1) @(negedge clk);
    readPortSelectN = 1'b0;
    writePortSelectN = 1'b0;
    addr = a;
    repeat (2) @(negedge clk);
    addr = a + 6'h01;
    @(negedge clk);
    readPortSelectN = 1'b1;
    writePortSelectN = 1'b1;
    addr = ~a;
    byteLaneWriteSelectN = 2'h0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      wrData = d[i];
    end
    @(negedge clk);
    wrData = ~wrData;
    byteLaneWriteSelectN = 2'h3;
  endtask
endmodule

// ---- qbs_mem.sv ----
// Lane-masked storage array with registered, write-first read data
`include "qbs_consts.svh"
module qbs_mem #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 21
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Array access
  qbs_mem_if.mem mif
);
  localparam int LANES = DATA_W / `QBS_LANE_W;

  logic [DATA_W-1:0] store [0:(2**ADDR_W)-1];
  logic [DATA_W-1:0] mergedRead;
  wire sameWord = mif.we && (mif.wAddr == mif.rAddr);

  // Same-beat write to the read word is forwarded so a read never sees stale lanes
  always_comb begin
    mergedRead = store[mif.rAddr];
    for (int l = 0; l < LANES; l++) begin
      if (sameWord && mif.wLane[l]) begin
        mergedRead[l*`QBS_LANE_W +: `QBS_LANE_W] = mif.wData[l*`QBS_LANE_W +: `QBS_LANE_W];
      end
    end
  end

  // Only enabled lanes change; the others keep their contents
  always_ff @(posedge clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (mif.we && mif.wLane[l]) begin
        store[mif.wAddr][l*`QBS_LANE_W +: `QBS_LANE_W] <= mif.wData[l*`QBS_LANE_W +: `QBS_LANE_W];
      end
    end
  end

  // Read data leave from a register
  always_ff @(posedge clk) begin
    if (srst) begin
      mif.rData <= '0;
    end else if (mif.re) begin
      mif.rData <= mergedRead;
    end
  end

  forward_new_a: assert property (@(posedge clk) disable iff (srst)
    (mif.re && sameWord && (&mif.wLane)) |=> (mif.rData == $past(mif.wData)))
    else $error("read beside a full write did not return the new word");
endmodule

// ---- qbs_mem_if.sv ----
// Array access signals between the port logic and the storage
interface qbs_mem_if #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 21
) ();
  logic we;
  logic [ADDR_W-1:0] wAddr;
  logic [DATA_W-1:0] wData;
  logic [DATA_W/9-1:0] wLane;
  logic re;
  logic [ADDR_W-1:0] rAddr;
  logic [DATA_W-1:0] rData;
  modport ctl (output we, output wAddr, output wData, output wLane, output re,
               output rAddr, input rData);
  modport mem (input we, input wAddr, input wData, input wLane, input re,
               input rAddr, output rData);
endinterface

// ---- qbs_pkg.sv ----
// Types of the quad burst SRAM port
package qbs_pkg;
  // Kind of operation started at the last positive clock rise
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } qbs_op_t;
endpackage

// ---- qbs_sram_port.sv ----
// Command, burst and byte-lane logic of a four-word burst SRAM port
`include "qbs_consts.svh"
module qbs_sram_port #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 21
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Command
  input wire logic readPortSelectN,
  input wire logic writePortSelectN,
  input wire logic [ADDR_W-1:0] addr,
  output logic kRise,
  // Write data, one word per beat
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [DATA_W/9-1:0] byteLaneWriteSelectN,
  // Read data, one word per beat
  output logic [DATA_W-1:0] rdData,
  output logic rdValid,
  output logic rdOe,
  input wire logic rdReady
);
  localparam int LANES = DATA_W / `QBS_LANE_W;

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (!(DATA_W == 18 || DATA_W == 36) || ADDR_W < 2) begin : g_bad_width
    $error("qbs_sram_port: DATA_W must be 18 or 36 and ADDR_W at least 2");
  end

  qbs_mem_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) mif ();

  qbs_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mem (
    .clk(clk),
    .srst(srst),
    .mif(mif)
  );

  // ------------------------------------------------------------
  // Beat phase and command arbitration
  // ------------------------------------------------------------
  logic kPhase;
  qbs_pkg::qbs_op_t lastOp;
  qbs_pkg::qbs_op_t next_lastOp;
  logic [1:0] rdLead;
  logic [ADDR_W-1:0] rdLeadAddr;
  logic wrLeadV;
  logic [ADDR_W-1:0] wrLeadAddr;

  // Each rising clk edge is one beat; even beats stand for the positive clock rise
  assign kRise = (kPhase == `QBS_PHASE_K);
  // A held-over read launch refuses a new read rather than overwrite it
  wire readReq = kRise && !readPortSelectN && (rdLead == 2'h0);
  wire writeReq = kRise && !writePortSelectN;
  wire startRead = readReq && (lastOp != qbs_pkg::OP_READ);
  wire startWrite = writeReq && (lastOp != qbs_pkg::OP_WRITE) && !startRead;

  // Last operation remembered across each positive clock rise
  always_comb begin
    next_lastOp = lastOp;
    case ({startRead, startWrite})
      2'b10: next_lastOp = qbs_pkg::OP_READ;
      2'b01: next_lastOp = qbs_pkg::OP_WRITE;
      2'b00: next_lastOp = qbs_pkg::OP_NONE;
      default: next_lastOp = qbs_pkg::OP_NONE;
    endcase
  end

  // Without clock edges nothing below moves, so state holds while stopped
  always_ff @(posedge clk) begin
    if (srst) begin
      kPhase <= `QBS_PHASE_K;
      lastOp <= qbs_pkg::OP_NONE;
    end else begin
      kPhase <= ~kPhase;
      if (kRise) begin
        lastOp <= next_lastOp;
      end
    end
  end

  // ------------------------------------------------------------
  // Write burst
  // ------------------------------------------------------------
  logic [2:0] wrLeft;
  logic [ADDR_W-1:0] wrAddr;
  wire wrActive = (wrLeft != 3'h0);

  // Spacing of two K cycles guarantees the old burst is on its last beat here
  always_ff @(posedge clk) begin
    if (srst) begin
      wrLeadV <= 1'b0;
      wrLeadAddr <= '0;
      wrLeft <= 3'h0;
      wrAddr <= '0;
    end else begin
      wrLeadV <= startWrite;
      if (startWrite) begin
        wrLeadAddr <= addr;
      end
      if (wrLeadV) begin
        wrLeft <= `QBS_BURST_LEN;
        wrAddr <= wrLeadAddr;
      end else if (wrActive) begin
        wrLeft <= wrLeft - 3'h1;
        wrAddr <= wrAddr + ADDR_W'(1);
      end
    end
  end

  // Write enable is on for every beat of the burst; lane selects are taken fresh each beat
  assign mif.we = wrActive;
  assign mif.wAddr = wrAddr;
  assign mif.wData = wrData;
  assign mif.wLane = ~byteLaneWriteSelectN;

  // ------------------------------------------------------------
  // Read burst and output buffer
  // ------------------------------------------------------------
  logic [2:0] rdLeft;
  logic [ADDR_W-1:0] rdAddr;
  logic memRdV;
  logic [DATA_W-1:0] bufData [0:1];
  logic bufWrPtr;
  logic bufRdPtr;
  logic [1:0] bufCount;

  wire pop = rdValid && rdReady;
  // Room counts the word already on its way out of the array
  wire [2:0] occupancy = 3'({1'b0, bufCount}) + 3'({2'b00, memRdV}) - 3'({2'b00, pop});
  wire canIssue = (occupancy < 3'({1'b0, `QBS_BUF_DEPTH}));
  wire issue = (rdLeft != 3'h0) && canIssue;
  wire rdLaunch = (rdLead == 2'h1) && ((rdLeft == 3'h0) || ((rdLeft == 3'h1) && issue));

  // Two beats of lead then four array reads, stalled by a full buffer
  always_ff @(posedge clk) begin
    if (srst) begin
      rdLead <= 2'h0;
      rdLeadAddr <= '0;
      rdLeft <= 3'h0;
      rdAddr <= '0;
    end else begin
      if (startRead) begin
        rdLead <= `QBS_RD_LEAD;
        rdLeadAddr <= addr;
      end else if (rdLead == 2'h2 || rdLaunch) begin
        rdLead <= rdLead - 2'h1;
      end
      if (rdLaunch) begin
        rdLeft <= `QBS_BURST_LEN;
        rdAddr <= rdLeadAddr;
      end else if (issue) begin
        rdLeft <= rdLeft - 3'h1;
        rdAddr <= rdAddr + ADDR_W'(1);
      end
    end
  end

  assign mif.re = issue;
  assign mif.rAddr = rdAddr;

  // Two-entry buffer: a stalled receiver loses no word
  always_ff @(posedge clk) begin
    if (srst) begin
      memRdV <= 1'b0;
      bufWrPtr <= 1'b0;
      bufRdPtr <= 1'b0;
      bufCount <= 2'h0;
    end else begin
      memRdV <= issue;
      if (memRdV) begin
        bufWrPtr <= ~bufWrPtr;
      end
      if (pop) begin
        bufRdPtr <= ~bufRdPtr;
      end
      bufCount <= bufCount + 2'({1'b0, memRdV}) - 2'({1'b0, pop});
    end
  end

  // Entries are data only, so they need no reset
  always_ff @(posedge clk) begin
    if (memRdV) begin
      bufData[bufWrPtr] <= mif.rData;
    end
  end

  assign rdValid = (bufCount != 2'h0);
  assign rdData = rdValid ? bufData[bufRdPtr] : '0;
  assign rdOe = rdValid;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  one_start_a: assert property (!(startRead && startWrite))
    else $error("read and write started on the same rise");
  read_first_a: assert property ((kRise && !readPortSelectN && !writePortSelectN
    && lastOp == qbs_pkg::OP_NONE && rdLead == 2'h0) |-> startRead)
    else $error("read did not win from the idle state");
  alt_write_a: assert property ((kRise && !writePortSelectN
    && lastOp == qbs_pkg::OP_READ) |-> startWrite)
    else $error("write did not follow a read");
  no_back_read_a: assert property (startRead |-> ##2 !startRead)
    else $error("read started on two consecutive rises");
  write_beats_a: assert property (startWrite |-> ##2 (wrLeft == `QBS_BURST_LEN)
    ##1 wrActive [*3] ##1 (!wrActive || wrLeft == `QBS_BURST_LEN))
    else $error("write burst did not take four beats after a lead of two");
  read_latency_a: assert property ((startRead && rdReady) ##1 rdReady [*4] |=> rdValid)
    else $error("first read word missing five beats after the start");
  burst_step_a: assert property ((wrActive && wrLeft != `QBS_BURST_LEN)
    |-> mif.wAddr == $past(mif.wAddr) + ADDR_W'(1))
    else $error("burst address did not step by one");
  lane_map_a: assert property (wrActive |-> mif.wLane == ~byteLaneWriteSelectN)
    else $error("lane enables do not follow the beat's selects");
  no_lane_a: assert property ((wrActive && (&byteLaneWriteSelectN)) |-> !(|mif.wLane))
    else $error("a fully deselected beat still wrote");
  idle_hiz_a: assert property ((bufCount == 2'h0 && !memRdV) |=> !rdOe)
    else $error("read outputs driven with no pending word");
  no_loss_a: assert property (!(memRdV && bufCount == `QBS_BUF_DEPTH && !pop))
    else $error("read word arrived at a full buffer");
endmodule

// ---- quad_burst_sram_port_tb.sv ----
// Self-checking bench of the quad burst SRAM port
module quad_burst_sram_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic readPortSelectN;
  logic writePortSelectN;
  logic [5:0] addr;
  logic [17:0] wrData;
  logic [1:0] byteLaneWriteSelectN;
  logic rdReady;
  logic kRise;
  logic [17:0] rdData;
  logic rdValid;
  logic rdOe;
  logic [17:0] mirror [64]; // Expected array contents
  logic [17:0] dA [4] = '{18'h1A5A5, 18'h25A5A, 18'h0F0F0, 18'h30F0F};
  logic [17:0] dB [4] = '{18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 18'h3FFFF};
  logic [17:0] dJ [4] = '{18'h2AAAA, 18'h15555, 18'h2AAAA, 18'h15555};
  logic [1:0] lAll [4] = '{2'h0, 2'h0, 2'h0, 2'h0};
  logic [1:0] lMix [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  int nErrors = 0;
  int checks = 0;

  // ----------------------------------------
  // Clock, design and controller
  // ----------------------------------------
  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  qbs_sram_port #(.DATA_W(18), .ADDR_W(6)) DUT (.clk(clk), .srst(srst),
    .readPortSelectN(readPortSelectN), .writePortSelectN(writePortSelectN), .addr(addr),
    .kRise(kRise), .wrData(wrData), .byteLaneWriteSelectN(byteLaneWriteSelectN),
    .rdData(rdData), .rdValid(rdValid), .rdOe(rdOe), .rdReady(rdReady));

  qbs_ctl_model ctl (.clk(clk), .kRise(kRise), .readPortSelectN(readPortSelectN),
    .writePortSelectN(writePortSelectN), .addr(addr), .wrData(wrData),
    .byteLaneWriteSelectN(byteLaneWriteSelectN), .rdReady(rdReady));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Compare and count
  task automatic check(input string name, input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Write burst, and the mirror follows the lane selects of each beat
  task automatic doWrite(input logic [5:0] a, input logic hold, input logic [17:0] d [4],
                         input logic [1:0] l [4]);
    logic [5:0] x;
    ctl.burst(1'b0, 1'b1, a, hold, d, l);
    for (int i = 0; i < 4; i++) begin
      x = a + 6'(i);
      if (!l[i][0]) mirror[x][8:0] = d[i][8:0];
      if (!l[i][1]) mirror[x][17:9] = d[i][17:9];
    end
  endtask

  // Read burst; junk beats with all lanes on catch a write that should not start
  task automatic rdChk(input logic [5:0] a, input logic wr, input logic hold, input logic stall);
    int n;
    int w;
    n = 0;
    w = 0;
    ctl.burst(1'b1, wr, a, hold, dJ, lAll);
    check("first valid", {17'h0, rdValid}, 18'h00001);
    check("first oe", {17'h0, rdOe}, 18'h00001);
    if (stall) begin
      ctl.rdReady = 1'b0;
      repeat (6) @(negedge clk);
      check("stalled head", rdData, mirror[a]);
      ctl.rdReady = 1'b1;
    end
    while (n < 4 && w < 20) begin
      if (rdValid === 1'b1) begin
        check("read word", rdData, mirror[a + 6'(n)]);
        n++;
      end
      @(negedge clk);
      w++;
    end
    check("burst end", {17'h0, rdValid}, 18'h00000);
    check("oe off", {17'h0, rdOe}, 18'h00000);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idle();
    check("first rise", {17'h0, kRise}, 18'h00001);
    @(negedge clk);
    check("rise toggles", {17'h0, kRise}, 18'h00000);
    repeat (3) @(negedge clk);
    check("idle oe", {17'h0, rdOe}, 18'h00000);
    check("idle data", rdData, 18'h00000);
    $display("test idle done");
  endtask

  // Burst wraps past the top address
  task automatic t_wrap();
    doWrite(6'h3E, 1'b0, dA, lAll);
    rdChk(6'h3E, 1'b0, 1'b0, 1'b0);
    $display("test wrap done");
  endtask

  // Lane pattern changes on every beat, one beat writes nothing
  task automatic t_lanes();
    doWrite(6'h3E, 1'b0, dB, lMix);
    rdChk(6'h3E, 1'b0, 1'b0, 1'b0);
    $display("test lanes done");
  endtask

  // Same select held into the next K rise starts nothing there
  task automatic t_repeat();
    rdChk(6'h3E, 1'b0, 1'b1, 1'b0);
    doWrite(6'h18, 1'b0, dA, lAll);
    doWrite(6'h10, 1'b1, dB, lAll);
    rdChk(6'h18, 1'b0, 1'b0, 1'b0);
    rdChk(6'h10, 1'b0, 1'b0, 1'b0);
    $display("test repeat done");
  endtask

  // Both selects from idle: the read wins
  task automatic t_both();
    rdChk(6'h3E, 1'b1, 1'b0, 1'b0);
    $display("test both done");
  endtask

  // Read, then the write wins the next both-selected rise; its beats reach the later read words
  task automatic t_fwd();
    logic [17:0] exp [4];
    int n;
    int w;
    exp = '{mirror[6'h18], dA[0], dA[1], dA[2]};
    n = 0;
    w = 0;
    fork
      ctl.rdThenWr(6'h18, dA);
      while (n < 4 && w < 20) begin
        @(negedge clk);
        w++;
        if (rdValid === 1'b1) begin
          check("forwarded word", rdData, exp[n]);
          n++;
        end
      end
    join
    for (int i = 0; i < 4; i++) begin
      mirror[6'h19 + 6'(i)] = dA[i];
    end
    check("forwarded count", 18'(n), 18'h00004);
    $display("test fwd done");
  endtask

  // Receiver stalls; no word may be lost
  task automatic t_stall();
    rdChk(6'h10, 1'b0, 1'b0, 1'b1);
    $display("test stall done");
  endtask

  // Verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    t_idle();
    t_wrap();
    t_lanes();
    t_repeat();
    t_both();
    t_fwd();
    t_stall();
    end_sim();
  end

  // Watchdog: the run needs far fewer than 2000 cycles
  initial begin
    #200000;
    nErrors++;
    end_sim();
  end
endmodule
